// File: rtl/reader_timer_pkg.sv
// Package of the reader down-counting timer: register indices, field layouts,
// reset values, tick-source and auto-start encodings, bus response codes.
// Assumes a 32-bit AXI4-Lite register bus; byte address is four times the index.
package reader_timer_pkg;

   // Register indices; byte address = 4 * index
   localparam logic [7:0] IDX_FIRST_COUNT_UPPER  = 8'h12;
   localparam logic [7:0] IDX_FIRST_COUNT_LOWER  = 8'h13;
   localparam logic [7:0] IDX_SECOND_CONTROL     = 8'h14;
   localparam logic [7:0] IDX_SECOND_RELOAD_UPPER = 8'h15;
   localparam logic [7:0] IDX_SECOND_RELOAD_LOWER = 8'h16;
   localparam logic [7:0] IDX_SECOND_COUNT_UPPER = 8'h17;
   localparam logic [7:0] IDX_RUN_CONTROL        = 8'h20;
   localparam logic [7:0] IDX_IRQ_STATUS         = 8'h21;
   localparam logic [7:0] IDX_IRQ_MASK           = 8'h22;

   // Reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] RELOAD_RESET  = 8'h00;
   localparam logic [1:0] IRQ_RESET     = 2'h0;

   // Control register: bits 6 and 2 are reserved and read as zero
   localparam logic [7:0] CONTROL_WRITE_MASK = 8'hBB;

   // Run control register bit positions
   localparam int unsigned RUN_ACTIVE_BIT   = 5;
   localparam int unsigned RUN_WRITE_EN_BIT = 1;

   // Counting clock rates and the derived divide ratio
   localparam int unsigned CARRIER_HZ    = 13_560_000;
   localparam int unsigned SLOW_TICK_HZ  = 211_875;
   localparam int unsigned SLOW_TICK_DIV = CARRIER_HZ / SLOW_TICK_HZ;
   localparam int unsigned SLOW_DIV_W    = $clog2(SLOW_TICK_DIV);

   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      START_NONE           = 2'b00,
      START_TX_END         = 2'b01,
      START_TRIM_PLAIN     = 2'b10,
      START_TRIM_UNDERFLOW = 2'b11
   } auto_start_t;

   typedef enum logic [1:0] {
      SRC_CARRIER         = 2'b00,
      SRC_SLOW            = 2'b01,
      SRC_FIRST_UNDERFLOW = 2'b10,
      SRC_THIRD_UNDERFLOW = 2'b11
   } tick_source_t;

   typedef struct packed {
      logic         halt_on_first_rx_bits;
      logic         rsv6;
      auto_start_t  auto_start_select;
      logic         reload_on_zero;
      logic         rsv2;
      tick_source_t tick_source_select;
   } timer_control_t;

   typedef struct packed {
      logic rx_halt;
      logic underflow;
   } irq_bits_t;

   typedef struct packed {
      logic tx_end;
      logic rx_first_bits;
   } radio_events_t;

   typedef struct packed {
      logic first_underflow;
      logic third_underflow;
   } cascade_t;

endpackage : reader_timer_pkg

// File: rtl/reader_timer_reload_counter.sv
// Second reader timer with reload, auto-start, trimming and cascading, plus
// readback of the first timer's count, behind an AXI4-Lite slave.
// Assumes all inputs synchronous to aclk; carrier_tick is one pulse per
// 13.56 MHz period, sibling underflows are one-cycle pulses.
// Behaviour
// RULE1: First timer count readable as two bytes
// RULE2: Software avoids counter reads during reception
// RULE3: Halt bit stops timer after four received bits
// RULE4: Halt bit ignored in trimming modes
// RULE5: Auto-start 00 none, 01 at transmit end
// RULE6: Auto-start 1x trims on slow oscillator edges
// RULE7: Reload-on-zero reloads and keeps counting; in plain trimming mode (10) the code stops at zero instead
// RULE8: Without reload, stop at zero
// RULE9: Every underflow sets the interrupt flag; the code sets no flag when the count hits zero in plain trimming mode (10)
// RULE10: Source 00 carrier, 01 divided slow tick
// RULE11: Source 10/11 cascades sibling timer underflows
// RULE12: Start event copies reload into counter
// RULE13: Reload writes wait for next start
// RULE14: Second timer upper count byte readable
// RULE15: Running bit writable only with write enable
// RULE16: Decrement per tick; underflow leaves zero
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
module reader_timer_reload_counter
   import reader_timer_pkg::*;
#(
   parameter int unsigned ADDR_W  = 12,
   parameter int unsigned COUNT_W = 16
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write address and data
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   // AXI4-Lite write response
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Radio and clock events
   input  wire radio_events_t     radio_events,
   input  wire logic              carrier_tick,
   input  wire logic              slow_oscillator,
   // Sibling timers
   input  wire logic [15:0]       first_timer_count,
   input  wire cascade_t          cascade,
   // Timer state and interrupt
   output logic                   second_timer_active,
   output logic                   second_timer_underflow,
   output logic                   irq
);

   function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
      reg_index = addr[9:2];
   endfunction : reg_index

   function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
      logic [7:0] idx;
      idx = addr[9:2];
      is_mapped = (addr[ADDR_W-1:10] == '0) &&
                  ((idx >= IDX_FIRST_COUNT_UPPER && idx <= IDX_SECOND_COUNT_UPPER) ||
                   (idx >= IDX_RUN_CONTROL && idx <= IDX_IRQ_MASK));
   endfunction : is_mapped

   timer_control_t     second_timer_control;
   logic [7:0]         second_timer_reload_upper;
   logic [7:0]         second_timer_reload_lower;
   logic [COUNT_W-1:0] count;
   irq_bits_t          irq_status;
   irq_bits_t          irq_mask;

   logic              aw_held;
   logic              w_held;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0]       w_data_q;
   logic              w_lane0_q;
   logic              wr_fire;
   logic              wr_lane;
   logic [7:0]        wr_idx;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Write channel: address and data are caught independently in any order
   assign wr_fire = aw_held && w_held && !bvalid;
   assign wr_idx  = reg_index(aw_addr_q);
   assign wr_lane = wr_fire && w_lane0_q && is_mapped(aw_addr_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held   <= 1'b0;
         awready   <= 1'b1;
         aw_addr_q <= '0;
      end else if (awvalid && awready) begin
         aw_held   <= 1'b1;
         awready   <= 1'b0;
         aw_addr_q <= awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held    <= 1'b0;
         wready    <= 1'b1;
         w_data_q  <= 32'h0000_0000;
         w_lane0_q <= 1'b0;
      end else if (wvalid && wready) begin
         w_held    <= 1'b1;
         wready    <= 1'b0;
         w_data_q  <= wdata;
         w_lane0_q <= wstrb[0];
      end else if (wr_fire) begin
         w_held <= 1'b0;
         wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp  <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         second_timer_control      <= timer_control_t'(CONTROL_RESET);
         second_timer_reload_upper <= RELOAD_RESET;
         second_timer_reload_lower <= RELOAD_RESET;
         irq_mask                  <= irq_bits_t'(IRQ_RESET);
      end else if (wr_lane) begin
         unique case (wr_idx)
            IDX_SECOND_CONTROL:
               second_timer_control <= timer_control_t'(w_data_q[7:0] & CONTROL_WRITE_MASK);
            IDX_SECOND_RELOAD_UPPER: second_timer_reload_upper <= w_data_q[7:0]; // [RULE13]
            IDX_SECOND_RELOAD_LOWER: second_timer_reload_lower <= w_data_q[7:0]; // [RULE13]
            IDX_IRQ_MASK:            irq_mask <= irq_bits_t'(w_data_q[1:0]);
            default: ;
         endcase
      end
   end

   // Tick sources
   logic [SLOW_DIV_W-1:0] slow_div;
   logic                  slow_tick;
   logic                  tick;
   logic                  osc_prev;
   logic                  osc_rise;

   assign slow_tick = carrier_tick && (slow_div == SLOW_DIV_W'(SLOW_TICK_DIV - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slow_div <= '0;
      end else if (carrier_tick) begin
         slow_div <= slow_tick ? '0 : slow_div + 1'b1; // [RULE10]
      end
   end

   always_comb begin
      unique case (second_timer_control.tick_source_select)
         SRC_CARRIER:         tick = carrier_tick;              // [RULE10]
         SRC_SLOW:            tick = slow_tick;                 // [RULE10]
         SRC_FIRST_UNDERFLOW: tick = cascade.first_underflow;   // [RULE11]
         SRC_THIRD_UNDERFLOW: tick = cascade.third_underflow;   // [RULE11]
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_prev <= 1'b0;
      end else begin
         osc_prev <= slow_oscillator;
      end
   end
   assign osc_rise = slow_oscillator && !osc_prev;

   // Counter events, in priority order
   auto_start_t mode;
   logic        trim;
   logic        sw_run_write;
   logic        sw_run_value;
   logic        tx_start;
   logic        trim_start;
   logic        trim_stop;
   logic        rx_stop;
   logic        zero_tick;
   logic        underflow_ev;
   logic [COUNT_W-1:0] reload_value;

   assign mode         = second_timer_control.auto_start_select;
   assign trim         = mode[1];
   assign reload_value = COUNT_W'({second_timer_reload_upper, second_timer_reload_lower});
   assign sw_run_write = wr_lane && wr_idx == IDX_RUN_CONTROL &&
                         w_data_q[RUN_WRITE_EN_BIT];                             // [RULE15]
   assign sw_run_value = w_data_q[RUN_ACTIVE_BIT];
   assign tx_start     = mode == START_TX_END && radio_events.tx_end;           // [RULE5]
   assign trim_start   = trim && osc_rise && !second_timer_active;              // [RULE6]
   assign trim_stop    = trim && osc_rise && second_timer_active;               // [RULE6]
   assign rx_stop      = second_timer_active && !trim &&
                         second_timer_control.halt_on_first_rx_bits &&
                         radio_events.rx_first_bits;                            // [RULE3] [RULE4]
   assign zero_tick    = second_timer_active && tick && count == '0;            // [RULE16]
   // Plain trimming mode stops at zero without reporting an underflow
   assign underflow_ev = zero_tick && mode != START_TRIM_PLAIN;                 // [RULE6]

   // Software control wins over hardware events in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         second_timer_active <= 1'b0;
         count               <= '0;
      end else if (sw_run_write) begin
         second_timer_active <= sw_run_value;                                   // [RULE15]
         if (sw_run_value) begin
            count <= reload_value;                                              // [RULE12]
         end
      end else if (tx_start || trim_start) begin
         second_timer_active <= 1'b1;
         count               <= reload_value;                                   // [RULE12]
      end else if (rx_stop || trim_stop) begin
         second_timer_active <= 1'b0;
      end else if (zero_tick) begin
         if (second_timer_control.reload_on_zero && mode != START_TRIM_PLAIN) begin
            count <= reload_value;                                              // [RULE7]
         end else begin
            second_timer_active <= 1'b0;                                        // [RULE8]
         end
      end else if (second_timer_active && tick) begin
         count <= count - 1'b1;                                                 // [RULE16]
      end
   end

   logic quiet;
   assign quiet = !sw_run_write && !tx_start && !trim_start && !rx_stop && !trim_stop;

   property p_halt_rx;
      rx_stop && !sw_run_write && !tx_start |=> !second_timer_active;
   endproperty
   a_halt_rx: assert property (p_halt_rx) else $error("timer kept running after rx halt"); // [RULE3]

   property p_trim_ignores_rx;
      trim && second_timer_active && radio_events.rx_first_bits && quiet && !zero_tick
         |=> second_timer_active;
   endproperty
   a_trim_ignores_rx: assert property (p_trim_ignores_rx) // [RULE4]
      else $error("trimming timer halted by receive");

   property p_tx_start;
      !sw_run_write && mode == START_TX_END && radio_events.tx_end
         |=> second_timer_active && count == $past(reload_value);
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("no start at transmit end"); // [RULE5]

   property p_trim_toggle;
      !sw_run_write && trim && osc_rise
         |=> second_timer_active != $past(second_timer_active);
   endproperty
   a_trim_toggle: assert property (p_trim_toggle) // [RULE6]
      else $error("trimming edges did not start then stop");

   property p_restart;
      zero_tick && quiet && second_timer_control.reload_on_zero && mode != START_TRIM_PLAIN
         |=> second_timer_active && count == $past(reload_value);
   endproperty
   a_restart: assert property (p_restart) else $error("no reload at zero"); // [RULE7]

   property p_stop_zero;
      zero_tick && quiet && !second_timer_control.reload_on_zero
         |=> !second_timer_active && count == '0;
   endproperty
   a_stop_zero: assert property (p_stop_zero) else $error("timer did not stop at zero"); // [RULE8]

   property p_decrement;
      second_timer_active && tick && count != '0 && quiet
         |=> count == $past(count) - 1'b1;
   endproperty
   a_decrement: assert property (p_decrement) else $error("count did not step down"); // [RULE16]

   property p_cascade_hold;
      second_timer_active && quiet &&
      second_timer_control.tick_source_select == SRC_FIRST_UNDERFLOW && !cascade.first_underflow
         |=> count == $past(count);
   endproperty
   a_cascade_hold: assert property (p_cascade_hold) // [RULE11]
      else $error("cascaded timer moved without sibling underflow");

   property p_reload_write_quiet;
      wr_lane && (wr_idx == IDX_SECOND_RELOAD_UPPER || wr_idx == IDX_SECOND_RELOAD_LOWER) &&
      second_timer_active && !tick && quiet
         |=> count == $past(count);
   endproperty
   a_reload_write_quiet: assert property (p_reload_write_quiet) // [RULE13]
      else $error("reload write disturbed running count");

   property p_sw_run;
      sw_run_write |=> second_timer_active == $past(sw_run_value);
   endproperty
   a_sw_run: assert property (p_sw_run) else $error("running bit write not honoured"); // [RULE15]

   // Sticky interrupt flags: a new event wins over a write-one-to-clear
   logic [1:0] status_clear;
   assign status_clear = (wr_lane && wr_idx == IDX_IRQ_STATUS) ? w_data_q[1:0] : 2'b00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= irq_bits_t'(IRQ_RESET);
      end else begin
         irq_status.underflow <= (irq_status.underflow && !status_clear[0]) ||
                                 underflow_ev;                                  // [RULE9]
         irq_status.rx_halt   <= (irq_status.rx_halt && !status_clear[1]) || rx_stop;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         second_timer_underflow <= 1'b0;
         irq                    <= 1'b0;
      end else begin
         second_timer_underflow <= underflow_ev;
         irq                    <= |(irq_status & irq_mask);
      end
   end

   property p_flag;
      underflow_ev |=> irq_status.underflow && second_timer_underflow;
   endproperty
   a_flag: assert property (p_flag) else $error("underflow did not set flag"); // [RULE9]

   // Read channel: one word answered per address, rvalid one cycle after
   logic [31:0] next_rdata;
   logic [7:0]  rd_idx;
   assign rd_idx = reg_index(araddr);

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (rd_idx)
         IDX_FIRST_COUNT_UPPER:   next_rdata[7:0] = first_timer_count[15:8];   // [RULE1]
         IDX_FIRST_COUNT_LOWER:   next_rdata[7:0] = first_timer_count[7:0];    // [RULE1]
         IDX_SECOND_CONTROL:      next_rdata[7:0] = second_timer_control;
         IDX_SECOND_RELOAD_UPPER: next_rdata[7:0] = second_timer_reload_upper;
         IDX_SECOND_RELOAD_LOWER: next_rdata[7:0] = second_timer_reload_lower;
         IDX_SECOND_COUNT_UPPER:  next_rdata[7:0] = count[COUNT_W-1 -: 8];     // [RULE14]
         IDX_RUN_CONTROL:         next_rdata[RUN_ACTIVE_BIT] = second_timer_active;
         IDX_IRQ_STATUS:          next_rdata[1:0] = irq_status;
         IDX_IRQ_MASK:            next_rdata[1:0] = irq_mask;
         default: ;
      endcase
      if (!is_mapped(araddr)) begin
         next_rdata = 32'h0000_0000;
      end
   end

   // Reads during reception return a live count; software is expected to avoid them [RULE2]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= next_rdata;
         rresp   <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   property p_first_lower;
      arvalid && arready && araddr == ADDR_W'({IDX_FIRST_COUNT_LOWER, 2'b00})
         |=> rvalid && rdata[7:0] == $past(first_timer_count[7:0]);
   endproperty
   a_first_lower: assert property (p_first_lower) else $error("wrong first count byte"); // [RULE1]

   property p_second_upper;
      arvalid && arready && araddr == ADDR_W'({IDX_SECOND_COUNT_UPPER, 2'b00})
         |=> rdata[7:0] == $past(count[COUNT_W-1 -: 8]) && rdata[31:8] == 24'h000000;
   endproperty
   a_second_upper: assert property (p_second_upper) // [RULE14]
      else $error("wrong second count byte");

endmodule : reader_timer_reload_counter

// File: test/tb.sv
// Self-checking bench of the reader reload timer: AXI4-Lite master tasks,
// an integer model of the second timer, and pulse drivers for its events.
// Assumes the package constants and a bus that answers within a few cycles.
`timescale 1ns/100ps
module tb;
   import reader_timer_pkg::*;
   logic          aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic          arvalid, arready, rvalid, rready, carrier_tick, slow_oscillator;
   logic          second_timer_active, second_timer_underflow, irq;
   logic [11:0]   awaddr, araddr;
   logic [31:0]   wdata, rdata;
   logic [3:0]    wstrb;
   logic [1:0]    bresp, rresp, m_status;
   logic [15:0]   first_timer_count, v;
   logic [7:0]    m_ctrl;
   radio_events_t radio_events;
   cascade_t      cascade;
   int            num_errors, n_compared, seed, m_count, m_reload, m_ufs;
   logic          m_active;

   reader_timer_reload_counter DUT (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .radio_events, .carrier_tick, .slow_oscillator, .first_timer_count,
      .cascade, .second_timer_active, .second_timer_underflow, .irq
   );

   always #2.5 aclk = ~aclk;

   task automatic print_verdict();
      if (num_errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   function automatic logic [11:0] ad(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : ad

   // Upper data bits are random: the design must ignore them
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
      awaddr <= a;
      wdata <= {24'($random(seed)), d};
      wstrb <= {3'($random(seed)), 1'b1};
      {awvalid, wvalid, bready} <= 3'b111;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk("bresp", bresp, er);
      bready <= 1'b0;
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er = 2'b00);
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      chk("rdata", rdata, {24'h0, e});
      chk("rresp", rresp, er);
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd

   task automatic setc(input logic [7:0] d);
      wr(ad(IDX_SECOND_CONTROL), d);
      m_ctrl = d;
   endtask : setc

   task automatic setr(input logic [15:0] d);
      wr(ad(IDX_SECOND_RELOAD_UPPER), d[15:8]);
      wr(ad(IDX_SECOND_RELOAD_LOWER), d[7:0]);
      m_reload = d;
   endtask : setr

   task automatic run(input logic go);
      wr(ad(IDX_RUN_CONTROL), {2'b00, go, 3'b000, 2'b10});
      m_active = go;
      m_count = m_reload;
      chk("active", second_timer_active, m_active);
   endtask : run

   // Status readback also checks the interrupt level, then clears it
   task automatic chkst();
      rd(ad(IDX_IRQ_STATUS), {6'h0, m_status});
      chk("irq", irq, |m_status);
      wr(ad(IDX_IRQ_STATUS), 8'h03);
      m_status = 2'b00;
      rd(ad(IDX_IRQ_STATUS), 8'h00);
      chk("irq", irq, 1'b0);
   endtask : chkst

   task automatic osc(input logic lv);
      slow_oscillator <= lv;
      repeat (2) @(posedge aclk);
      #1;
   endtask : osc

   // Kinds: 0 carrier, 1 first underflow, 2 third underflow, 3 tx end, 4 rx bits
   task automatic pulse(input int k, input logic c = 1'b1);
      logic tk;
      logic uf;
      case (k)
         0: carrier_tick <= 1'b1;
         1: cascade.first_underflow <= 1'b1;
         2: cascade.third_underflow <= 1'b1;
         3: radio_events.tx_end <= 1'b1;
         default: radio_events.rx_first_bits <= 1'b1;
      endcase
      @(posedge aclk);
      {carrier_tick, cascade, radio_events} <= '0;
      #1;
      tk = (k == 0 && m_ctrl[1:0] == 0) || (k == 1 && m_ctrl[1:0] == 2)
         || (k == 2 && m_ctrl[1:0] == 3);
      uf = 1'b0;
      if (k == 3 && m_ctrl[5:4] == 2'b01) begin
         m_active = 1'b1;
         m_count = m_reload;
      end
      if (k == 4 && m_ctrl[7] && !m_ctrl[5] && m_active) begin
         m_active = 1'b0;
         m_status[1] = 1'b1;
      end
      if (tk && m_active) begin
         if (m_count == 0) begin
            uf = m_ctrl[5:4] != 2'b10;
            m_status[0] |= uf;
            if (m_ctrl[3] && uf) m_count = m_reload;
            else m_active = 1'b0;
         end else begin
            m_count--;
         end
      end
      m_ufs += int'(second_timer_underflow);
      if (c) begin
         chk("underflow", second_timer_underflow, uf);
         chk("active", second_timer_active, m_active);
      end
   endtask : pulse

   initial begin
      #50000;
      num_errors++;
      print_verdict();
   end

   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {carrier_tick, slow_oscillator, cascade, radio_events} = '0;
      {awaddr, araddr, wdata, wstrb, first_timer_count} = '0;
      {num_errors, n_compared, m_count, m_reload, m_ufs, m_status, m_ctrl, m_active} = '0;
      seed = 32'h846d;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      chk("idle", {bvalid, rvalid, second_timer_active, irq}, 0);
      foreach (v[i]) if (i < 6) rd(ad(8'h12 + 8'(i)), 8'h00);
      wr(ad(IDX_SECOND_CONTROL), 8'hFF);
      rd(ad(IDX_SECOND_CONTROL), 8'hBB);
      wr(ad(IDX_SECOND_COUNT_UPPER), 8'h55);
      rd(ad(IDX_SECOND_COUNT_UPPER), 8'h00);
      wr(12'hC00, 8'h01, RESP_SLVERR);
      rd(12'hC00, 8'h00, RESP_SLVERR);
      // Counts are read only while no reception is under way
      repeat (3) begin
         v = 16'($random(seed));
         first_timer_count <= v;
         rd(ad(IDX_FIRST_COUNT_UPPER), v[15:8]);
         rd(ad(IDX_FIRST_COUNT_LOWER), v[7:0]);
      end
      wr(ad(IDX_IRQ_MASK), 8'h03);
      setc(8'h08);
      setr(16'h0102);
      wr(ad(IDX_RUN_CONTROL), 8'h20);
      chk("active", second_timer_active, 1'b0);
      run(1'b1);
      rd(ad(IDX_SECOND_COUNT_UPPER), 8'h01);
      setr(16'h0001);
      repeat (3) pulse(0);
      rd(ad(IDX_SECOND_COUNT_UPPER), 8'(m_count >> 8));
      repeat (m_count + 5) pulse(0);
      chkst();
      run(1'b0);
      setc(8'h00);
      setr(16'h0002);
      run(1'b1);
      repeat (5) pulse(0);
      chkst();
      for (int a = 0; a < 2; a++) begin
         setc(8'h08 | 8'(a << 4));
         pulse(3);
         pulse(0);
         run(1'b0);
      end
      for (int h = 0; h < 2; h++) begin
         setc(8'h08 | 8'(h << 7));
         run(1'b1);
         pulse(4);
         run(1'b0);
      end
      chkst();
      for (int t = 2; t < 4; t++) begin
         setc(8'h80 | 8'(t << 4));
         osc(1'b1);
         m_active = 1'b1;
         chk("active", second_timer_active, 1'b1);
         pulse(4);
         osc(1'b0);
         osc(1'b1);
         m_active = 1'b0;
         chk("active", second_timer_active, 1'b0);
         osc(1'b0);
         // Restart and run into zero: only the underflow variant flags it
         osc(1'b1);
         m_active = 1'b1;
         m_count = m_reload;
         repeat (3) pulse(0);
         osc(1'b0);
      end
      setr(16'h0000);
      for (int s = 2; s < 4; s++) begin
         setc(8'h08 | 8'(s));
         run(1'b1);
         for (int k = 0; k < 3; k++) pulse(k);
         run(1'b0);
      end
      chkst();
      setc(8'h09);
      run(1'b1);
      m_ufs = 0;
      repeat (128) pulse(0, 1'b0);
      chk("slow ticks", m_ufs, 2);
      m_status[0] = 1'b1;
      run(1'b0);
      chkst();
      print_verdict();
   end
endmodule : tb
